// >>> pcsm_pkg.sv
/*
  Constants for the per-port clock source multiplexer: register offsets,
  field positions, reset values, loopback codes and source encodings.
  Assumes a single 250 MHz bus clock and a 32-bit AHB-Lite register port.
*/
// Functional notes
// RULE_01 - Receive logic runs from receive line clock unless looped or overridden
// RULE_02 - Transmit logic defaults to the rate adapter, not the transmit clock pin
// RULE_03 - Line mode, loopback field, loop timing and bypass select held in registers
// RULE_04 - Loop timing sends receive line clock to all three clocks and outputs
// RULE_05 - No loopback: receive framer on line clock, line clock equals framer clock
// RULE_06 - Line or line plus diagnostic loopback: line clock output from receive clock
// RULE_07 - No line loopback: line clock from adapter at bypass 0, pin at 1
// RULE_08 - Payload loopback: framer and line clocks all follow receive line clock
// RULE_09 - Without payload loopback, transmit clock from adapter or pin per bypass
// RULE_10 - Without diagnostic or analog loopback, receive clock from line clock pin
// RULE_11 - Diagnostic loopback: receive clock from adapter or pin; analog plus bypass uses pin
// RULE_12 - Diagnostic alone: receive framer and line clock equal transmit framer clock
// RULE_13 - Line plus diagnostic: receive framer from transmit, line clock from receive pin
// RULE_14 - Transmit line data timed to the transmit line clock output's source
// RULE_15 - Line timing select: 0 output-pin timing, 1 input-pin timing
// RULE_16 - No loopback, line select 0: line or framer clock output valid references
// RULE_17 - Line select 1 without line loops: input pin valid only at bypass 1
// RULE_18 - Transmit framer data timed to the transmit framer clock output's source
// RULE_19 - Framer timing select: 0 output-pin timing, 1 input-pin timing
// RULE_20 - Framer select 1: receive pin in payload loop, else pin only at bypass 1
// RULE_21 - Software changes clock selects only while the port is idle or reset
package pcsm_pkg;
  // Register byte offsets
  localparam logic [7:0] PCSM_OFS_CTRL3 = 8'h00;
  localparam logic [7:0] PCSM_OFS_CTRL4 = 8'h04;
  localparam logic [7:0] PCSM_OFS_ADAPT = 8'h08;
  localparam logic [7:0] PCSM_OFS_STAT = 8'h0C;
  // port_control_three fields
  localparam int PCSM_B_LOOP_TIMING_SELECT = 0;
  localparam int PCSM_B_BYP = 1;
  localparam int PCSM_B_TX_LINE_TIMING_SELECT = 2;
  localparam int PCSM_B_TX_FRAMER_TIMING_SELECT = 3;
  // port_control_four fields
  localparam int PCSM_B_LBM = 0;
  localparam int PCSM_B_LMODE = 4;
  // Status fields
  localparam int PCSM_B_RXSEL = 0;
  localparam int PCSM_B_TXSEL = 4;
  localparam int PCSM_B_LNSEL = 8;
  localparam int PCSM_B_LNMASK = 12;
  localparam int PCSM_B_FRMASK = 20;
  localparam int PCSM_B_LVL = 28;
  // Reset values
  localparam logic [3:0] PCSM_RST_CTRL3 = 4'h0;
  localparam logic [2:0] PCSM_RST_LBM = 3'h0;
  localparam logic [1:0] PCSM_RST_LMODE = 2'h0;
  localparam logic [7:0] PCSM_RST_ADAPT = 8'h02;
  // Loopback field codes
  localparam logic [2:0] PCSM_LB_NONE = 3'h0;
  localparam logic [2:0] PCSM_LB_ANALOG = 3'h1;
  localparam logic [2:0] PCSM_LB_LINE = 3'h2;
  localparam logic [2:0] PCSM_LB_PAYLOAD = 3'h3;
  localparam logic [2:0] PCSM_LB_DIAG = 3'h4;
  localparam logic [2:0] PCSM_LB_LINEDIAG = 3'h6;
  // One-hot clock source codes
  localparam logic [2:0] PCSM_SRC_RX = 3'h1;
  localparam logic [2:0] PCSM_SRC_TX = 3'h2;
  localparam logic [2:0] PCSM_SRC_AD = 3'h4;
  // Valid-reference mask bits
  localparam int PCSM_V_TLCLK = 0;
  localparam int PCSM_V_TCLKO = 1;
  localparam int PCSM_V_RCLKO = 2;
  localparam int PCSM_V_RXPIN = 3;
  localparam int PCSM_V_TXPIN = 4;
  localparam logic [2:0] PCSM_WORD_SIZE = 3'h2;
endpackage

// >>> pcsm_port_clock_mux.sv
/*
  Per-port clock source multiplexer with AHB-Lite control registers.
  Picks receive framer, transmit framer and transmit line clocks from the
  receive line clock pin, transmit clock pin or internal rate adapter,
  and reports which pins are valid timing references.
  Assumes pin clocks are far slower than hclk; they are sampled as levels.
*/
`timescale 1ns/1ps
`default_nettype none
module pcsm_port_clock_mux
  import pcsm_pkg::*;
(
  input wire logic hclk, // Bus clock, 250 MHz
  input wire logic hresetn, // Async reset, active low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Transfer size
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  output logic hreadyout, // Always ready
  output logic hresp, // Always OKAY
  output logic [31:0] hrdata, // Read data
  input wire logic rx_line_clock_input, // Receive line clock pin
  input wire logic tx_clock_input, // Transmit clock pin
  output logic rx_framer_clock_output, // Receive framer clock
  output logic tx_framer_clock_output, // Transmit framer clock
  output logic tx_line_clock_output, // Transmit line clock
  output logic tx_line_data_en, // Line data strobe
  output logic tx_framer_data_en, // Framer data strobe
  output logic tx_line_timing_select, // Line pin timing mode
  output logic tx_framer_timing_select, // Framer pin timing mode
  output logic [4:0] tx_line_ref_valid, // Valid line references
  output logic [4:0] tx_framer_ref_valid // Valid framer references
);
  import pcsm_pkg::*;

  logic [3:0] ctrl3_q;
  logic [2:0] loopback_mode_field_q;
  logic [1:0] line_mode_bits_q;
  logic [7:0] adapt_half_q;
  logic [7:0] adapt_cnt_q;
  logic clock_rate_adapter_q;
  logic [1:0] pin_meta_q;
  logic [1:0] pin_sync_q;
  logic loop_timing_select;
  logic adapter_bypass_select;
  logic [2:0] rx_sel_d;
  logic [2:0] tx_sel_d;
  logic [2:0] line_sel_d;
  logic [4:0] line_mask_d;
  logic [4:0] framer_mask_d;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic addr_ok;
  logic [31:0] rd_word;

  // Pick the level of one of the three sources
  function automatic logic src_level(input logic [2:0] sel, input logic rx,
                                     input logic tx, input logic ad);
    logic lvl;
    lvl = 1'b0;
    case (sel)
      PCSM_SRC_RX: lvl = rx;
      PCSM_SRC_TX: lvl = tx;
      PCSM_SRC_AD: lvl = ad;
      default: lvl = 1'b0;
    endcase
    return lvl;
  endfunction

  // Loopbacks that hand the transmit line to the receive clock
  function automatic logic line_from_rx(input logic [2:0] lb);
    return (lb == PCSM_LB_LINE) || (lb == PCSM_LB_LINEDIAG) || (lb == PCSM_LB_PAYLOAD);
  endfunction

  assign loop_timing_select = ctrl3_q[PCSM_B_LOOP_TIMING_SELECT];
  assign adapter_bypass_select = ctrl3_q[PCSM_B_BYP];
  assign tx_line_timing_select = ctrl3_q[PCSM_B_TX_LINE_TIMING_SELECT]; // RULE_15
  assign tx_framer_timing_select = ctrl3_q[PCSM_B_TX_FRAMER_TIMING_SELECT]; // RULE_19

  // Two-stage synchronisers for both pin clocks
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_meta_q <= 2'h0;
      pin_sync_q <= 2'h0;
    end else begin
      pin_meta_q <= {tx_clock_input, rx_line_clock_input};
      pin_sync_q <= pin_meta_q;
    end
  end

  // Rate adapter: divider toggling every adapt_half_q + 1 cycles
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      adapt_cnt_q <= 8'h00;
      clock_rate_adapter_q <= 1'b0;
    end else if (adapt_cnt_q >= adapt_half_q) begin
      adapt_cnt_q <= 8'h00;
      clock_rate_adapter_q <= ~clock_rate_adapter_q;
    end else begin
      adapt_cnt_q <= adapt_cnt_q + 8'h01;
    end
  end

  // Source selection; loop timing overrides every loopback
  always_comb begin
    if (loop_timing_select) begin
      rx_sel_d = PCSM_SRC_RX; // RULE_04
      tx_sel_d = PCSM_SRC_RX; // RULE_04
      line_sel_d = PCSM_SRC_RX; // RULE_04
    end else begin
      // Transmit framer: payload loop follows receive, else bypass picks
      if (loopback_mode_field_q == PCSM_LB_PAYLOAD) begin
        tx_sel_d = PCSM_SRC_RX; // RULE_08
      end else if (adapter_bypass_select) begin
        tx_sel_d = PCSM_SRC_TX; // RULE_09
      end else begin
        tx_sel_d = PCSM_SRC_AD; // RULE_02 RULE_09
      end
      // Receive framer: diagnostic and analog loops turn it to transmit
      if (loopback_mode_field_q[2]) begin
        rx_sel_d = adapter_bypass_select ? PCSM_SRC_TX : PCSM_SRC_AD; // RULE_11 RULE_12 RULE_13
      end else if (loopback_mode_field_q == PCSM_LB_ANALOG) begin
        rx_sel_d = adapter_bypass_select ? PCSM_SRC_TX : PCSM_SRC_AD; // RULE_11
      end else begin
        rx_sel_d = PCSM_SRC_RX; // RULE_01 RULE_05 RULE_10
      end
      // Transmit line: line and payload loops take the receive pin, else bypass picks
      if (line_from_rx(loopback_mode_field_q)) begin
        line_sel_d = PCSM_SRC_RX; // RULE_06 RULE_08 RULE_13
      end else begin
        line_sel_d = adapter_bypass_select ? PCSM_SRC_TX : PCSM_SRC_AD; // RULE_05 RULE_07 RULE_12
      end
    end
  end

  // Valid timing references for the transmit line pins
  always_comb begin
    line_mask_d = 5'h00;
    if (loop_timing_select) begin
      if (tx_line_timing_select) begin
        line_mask_d[PCSM_V_RXPIN] = 1'b1;
      end else begin
        line_mask_d[PCSM_V_TLCLK] = 1'b1;
        line_mask_d[PCSM_V_TCLKO] = 1'b1;
        line_mask_d[PCSM_V_RCLKO] = 1'b1;
      end
    end else if (tx_line_timing_select) begin
      if (line_from_rx(loopback_mode_field_q)) begin
        line_mask_d[PCSM_V_RXPIN] = 1'b1;
      end else begin
        line_mask_d[PCSM_V_TXPIN] = adapter_bypass_select; // RULE_17
      end
    end else begin
      line_mask_d[PCSM_V_TLCLK] = 1'b1;
      case (loopback_mode_field_q)
        PCSM_LB_DIAG: begin
          line_mask_d[PCSM_V_TCLKO] = 1'b1;
          line_mask_d[PCSM_V_RCLKO] = 1'b1;
        end
        PCSM_LB_LINE, PCSM_LB_PAYLOAD: begin
          line_mask_d[PCSM_V_RCLKO] = 1'b1;
        end
        PCSM_LB_LINEDIAG: begin
          line_mask_d[PCSM_V_TLCLK] = 1'b1;
        end
        default: begin
          line_mask_d[PCSM_V_TCLKO] = 1'b1; // RULE_16
        end
      endcase
    end
  end

  // Valid timing references for the transmit framer pins
  always_comb begin
    framer_mask_d = 5'h00;
    if (loop_timing_select) begin
      if (tx_framer_timing_select) begin
        framer_mask_d[PCSM_V_RXPIN] = 1'b1;
      end else begin
        framer_mask_d[PCSM_V_TLCLK] = 1'b1;
        framer_mask_d[PCSM_V_TCLKO] = 1'b1;
        framer_mask_d[PCSM_V_RCLKO] = 1'b1;
      end
    end else if (tx_framer_timing_select) begin
      if (loopback_mode_field_q == PCSM_LB_PAYLOAD) begin
        framer_mask_d[PCSM_V_RXPIN] = 1'b1; // RULE_20
      end else begin
        framer_mask_d[PCSM_V_TXPIN] = adapter_bypass_select; // RULE_20
      end
    end else begin
      framer_mask_d[PCSM_V_TCLKO] = 1'b1;
      case (loopback_mode_field_q)
        PCSM_LB_PAYLOAD, PCSM_LB_DIAG, PCSM_LB_ANALOG: begin
          framer_mask_d[PCSM_V_TLCLK] = 1'b1;
          framer_mask_d[PCSM_V_RCLKO] = 1'b1;
        end
        PCSM_LB_LINEDIAG: begin
          framer_mask_d[PCSM_V_RCLKO] = 1'b1;
        end
        PCSM_LB_NONE: begin
          framer_mask_d[PCSM_V_TLCLK] = 1'b1;
        end
        default: begin
          framer_mask_d[PCSM_V_TCLKO] = 1'b1;
        end
      endcase
    end
  end

  // Clock outputs and data strobes; strobes mark rising edges of the
  // chosen clock so data shares the clock output's source
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_framer_clock_output <= 1'b0;
      tx_framer_clock_output <= 1'b0;
      tx_line_clock_output <= 1'b0;
      tx_line_data_en <= 1'b0;
      tx_framer_data_en <= 1'b0;
    end else begin
      rx_framer_clock_output <= src_level(rx_sel_d, pin_sync_q[0], pin_sync_q[1], clock_rate_adapter_q);
      tx_framer_clock_output <= src_level(tx_sel_d, pin_sync_q[0], pin_sync_q[1], clock_rate_adapter_q);
      tx_line_clock_output <= src_level(line_sel_d, pin_sync_q[0], pin_sync_q[1], clock_rate_adapter_q);
      tx_line_data_en <= src_level(line_sel_d, pin_sync_q[0], pin_sync_q[1], clock_rate_adapter_q)
                         & ~tx_line_clock_output; // RULE_14
      tx_framer_data_en <= src_level(tx_sel_d, pin_sync_q[0], pin_sync_q[1], clock_rate_adapter_q)
                           & ~tx_framer_clock_output; // RULE_18
    end
  end

  // Reference masks registered for clean pins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_line_ref_valid <= 5'h00;
      tx_framer_ref_valid <= 5'h00;
    end else begin
      tx_line_ref_valid <= line_mask_d; // RULE_15 RULE_16 RULE_17
      tx_framer_ref_valid <= framer_mask_d; // RULE_19 RULE_20
    end
  end

  // Bus slave: zero wait states, OKAY always
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addr_ok = hsel && hready && htrans[1] && (hsize == PCSM_WORD_SIZE);

  // Read mux of the address-phase offset
  always_comb begin
    rd_word = 32'h0000_0000;
    case (haddr[7:0])
      PCSM_OFS_CTRL3: rd_word[3:0] = ctrl3_q;
      PCSM_OFS_CTRL4: begin
        rd_word[PCSM_B_LBM +: 3] = loopback_mode_field_q;
        rd_word[PCSM_B_LMODE +: 2] = line_mode_bits_q;
      end
      PCSM_OFS_ADAPT: rd_word[7:0] = adapt_half_q;
      PCSM_OFS_STAT: begin
        rd_word[PCSM_B_RXSEL +: 3] = rx_sel_d;
        rd_word[PCSM_B_TXSEL +: 3] = tx_sel_d;
        rd_word[PCSM_B_LNSEL +: 3] = line_sel_d;
        rd_word[PCSM_B_LNMASK +: 5] = tx_line_ref_valid;
        rd_word[PCSM_B_FRMASK +: 5] = tx_framer_ref_valid;
        rd_word[PCSM_B_LVL +: 3] = {tx_line_clock_output, tx_framer_clock_output, rx_framer_clock_output};
      end
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Address phase capture; read data is loaded for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata <= 32'h0000_0000;
    end else if (hready) begin
      wr_pend_q <= addr_ok && hwrite && (haddr[31:8] == 24'h00_0000);
      wr_addr_q <= haddr[7:0];
      hrdata <= (addr_ok && !hwrite && (haddr[31:8] == 24'h00_0000)) ? rd_word : 32'h0000_0000;
    end
  end

  // Configuration registers written in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl3_q <= PCSM_RST_CTRL3;
      loopback_mode_field_q <= PCSM_RST_LBM;
      line_mode_bits_q <= PCSM_RST_LMODE;
      adapt_half_q <= PCSM_RST_ADAPT;
    end else if (wr_pend_q) begin
      case (wr_addr_q)
        PCSM_OFS_CTRL3: ctrl3_q <= hwdata[3:0]; // RULE_03
        PCSM_OFS_CTRL4: begin
          loopback_mode_field_q <= hwdata[PCSM_B_LBM +: 3]; // RULE_03
          line_mode_bits_q <= hwdata[PCSM_B_LMODE +: 2]; // RULE_03
        end
        PCSM_OFS_ADAPT: adapt_half_q <= hwdata[7:0];
        default: adapt_half_q <= adapt_half_q;
      endcase
    end
  end

  // Checks on source selection and reference reporting
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  loop_timed_a: assert property (loop_timing_select |-> ##1 // RULE_04
      (tx_line_clock_output == $past(pin_sync_q[0])) && (rx_framer_clock_output == $past(pin_sync_q[0])))
    else $error("loop timing does not follow receive pin");
  rx_default_a: assert property (!loop_timing_select && !loopback_mode_field_q[2] // RULE_01
      && loopback_mode_field_q != PCSM_LB_ANALOG |-> rx_sel_d == PCSM_SRC_RX)
    else $error("receive framer not on line clock");
  tx_default_a: assert property (!loop_timing_select && !adapter_bypass_select // RULE_02
      && loopback_mode_field_q != PCSM_LB_PAYLOAD |=> tx_framer_clock_output == $past(clock_rate_adapter_q))
    else $error("transmit framer not on adapter");
  line_loop_a: assert property (!loop_timing_select && (loopback_mode_field_q == PCSM_LB_LINE // RULE_06
      || loopback_mode_field_q == PCSM_LB_LINEDIAG) |-> line_sel_d == PCSM_SRC_RX)
    else $error("line loopback line clock not from receive pin");
  line_bypass_a: assert property (!loop_timing_select && !line_from_rx(loopback_mode_field_q) // RULE_07
      |-> line_sel_d == (adapter_bypass_select ? PCSM_SRC_TX : PCSM_SRC_AD))
    else $error("line clock ignores bypass select");
  payload_loop_a: assert property (!loop_timing_select && loopback_mode_field_q == PCSM_LB_PAYLOAD // RULE_08
      |-> tx_sel_d == PCSM_SRC_RX && line_sel_d == PCSM_SRC_RX && rx_sel_d == PCSM_SRC_RX)
    else $error("payload loopback sources wrong");
  diag_loop_a: assert property (!loop_timing_select && loopback_mode_field_q == PCSM_LB_DIAG // RULE_12
      |-> rx_sel_d == tx_sel_d && line_sel_d == tx_sel_d)
    else $error("diagnostic loopback sources differ");
  line_diag_a: assert property (!loop_timing_select && loopback_mode_field_q == PCSM_LB_LINEDIAG // RULE_13
      |-> rx_sel_d == tx_sel_d && line_sel_d == PCSM_SRC_RX)
    else $error("combined loopback sources wrong");
  line_strobe_a: assert property (tx_line_data_en |-> tx_line_clock_output && !$past(tx_line_clock_output)) // RULE_14
    else $error("line strobe not on line clock edge");
  line_input_a: assert property (!loop_timing_select && tx_line_timing_select // RULE_17
      && !line_from_rx(loopback_mode_field_q) |=> tx_line_ref_valid == {$past(adapter_bypass_select), 4'h0})
    else $error("line input reference wrong");
  framer_input_a: assert property (!loop_timing_select && tx_framer_timing_select // RULE_20
      && loopback_mode_field_q == PCSM_LB_PAYLOAD |=> tx_framer_ref_valid == 5'h08)
    else $error("framer payload reference wrong");

  loop_timed_c: cover property (loop_timing_select && tx_line_data_en);
  diag_bypass_c: cover property (loopback_mode_field_q == PCSM_LB_DIAG && adapter_bypass_select && tx_framer_data_en);
  no_ref_c: cover property (tx_line_timing_select && tx_line_ref_valid == 5'h00 && !loop_timing_select);
  payload_c: cover property (!loop_timing_select && loopback_mode_field_q == PCSM_LB_PAYLOAD && tx_line_data_en);
  combo_c: cover property (!loop_timing_select && loopback_mode_field_q == PCSM_LB_LINEDIAG && tx_framer_data_en);

  // Checks on the driven output pins rather than the select codes
  rx_line_a: assert property (!loop_timing_select && !loopback_mode_field_q[2] // RULE_10
      && loopback_mode_field_q != PCSM_LB_ANALOG
      |=> rx_framer_clock_output == $past(pin_sync_q[0]))
    else $error("receive framer not on receive pin");
  rx_diag_a: assert property (!loop_timing_select && loopback_mode_field_q[2] // RULE_11
      |=> rx_framer_clock_output == $past(adapter_bypass_select ? pin_sync_q[1] : clock_rate_adapter_q))
    else $error("diagnostic receive source wrong");
  tx_pin_a: assert property (!loop_timing_select && adapter_bypass_select // RULE_09
      && loopback_mode_field_q != PCSM_LB_PAYLOAD |=> tx_framer_clock_output == $past(pin_sync_q[1]))
    else $error("transmit framer not on transmit pin");
  no_loop_a: assert property (!loop_timing_select && loopback_mode_field_q == PCSM_LB_NONE // RULE_05
      |=> tx_line_clock_output == tx_framer_clock_output)
    else $error("line clock differs from framer clock");
  diag_out_a: assert property (!loop_timing_select && loopback_mode_field_q == PCSM_LB_DIAG // RULE_12
      |=> rx_framer_clock_output == tx_framer_clock_output && tx_line_clock_output == tx_framer_clock_output)
    else $error("diagnostic clocks differ");
  framer_strobe_a: assert property (tx_framer_data_en // RULE_18
      |-> tx_framer_clock_output && !$past(tx_framer_clock_output))
    else $error("framer strobe not on clock edge");
  line_output_a: assert property (!tx_line_timing_select |=> tx_line_ref_valid[PCSM_V_TLCLK]) // RULE_15
    else $error("line clock output not offered");
  framer_output_a: assert property (!tx_framer_timing_select |=> tx_framer_ref_valid[PCSM_V_TCLKO]) // RULE_19
    else $error("framer clock output not offered");
  line_default_a: assert property (!loop_timing_select && !tx_line_timing_select // RULE_16
      && loopback_mode_field_q == PCSM_LB_NONE |=> tx_line_ref_valid[PCSM_V_TCLKO])
    else $error("framer clock output not offered for line");
endmodule
`default_nettype wire

// >>> pcsm_far_end_model.sv
/*
  Far-end logic model: makes the receive line clock and the transmit clock.
  Assumes the bench stops it while clock selects are rewritten.
*/
`timescale 1ns/1ps
`default_nettype none
module pcsm_far_end_model (
  input wire logic run, // Let both clocks toggle
  output logic rx_line_clock_input, // Receive line clock to the port
  output logic tx_clock_input // Transmit clock to the port
);
  // Receive clock, 20 ns period; parks high so held levels differ per pin
  // Steps fall on odd ns, clear of every hclk edge
  initial begin
    rx_line_clock_input = 1'b1;
    #1;
    forever begin
      #10;
      rx_line_clock_input = run ? ~rx_line_clock_input : 1'b1;
    end
  end
  // Transmit clock, 36 ns period, odd-ns steps; parks low
  initial begin
    tx_clock_input = 1'b0;
    #1;
    forever begin
      #18;
      tx_clock_input = run ? ~tx_clock_input : 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> tb_port_clock_source_mux.sv
/*
  Self-checking bench for the port clock source multiplexer.
  Assumes pcsm_pkg, the mux and the far-end model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_port_clock_source_mux;
  import pcsm_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic run = 1'b0;
  wire logic hreadyout, hresp, rxc, txc, rxfr, txfr, lnc, lden, fden, ltsel, ftsel;
  wire logic [31:0] hrdata;
  wire logic [4:0] lref, fref;
  int n_mismatch = 0;
  int total_checks = 0;
  logic [15:0] lf = 16'h8D98;
  localparam logic [31:0] A3 = {24'h00_0000, PCSM_OFS_CTRL3};
  localparam logic [31:0] A4 = {24'h00_0000, PCSM_OFS_CTRL4};
  localparam logic [31:0] AS = {24'h00_0000, PCSM_OFS_STAT};
  localparam logic [31:0] AA = {24'h00_0000, PCSM_OFS_ADAPT};

  // 250 MHz bus clock
  always #2 hclk = ~hclk;

  pcsm_port_clock_mux pcsm_port_clock_mux_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .rx_line_clock_input(rxc), .tx_clock_input(txc),
    .rx_framer_clock_output(rxfr), .tx_framer_clock_output(txfr), .tx_line_clock_output(lnc),
    .tx_line_data_en(lden), .tx_framer_data_en(fden),
    .tx_line_timing_select(ltsel), .tx_framer_timing_select(ftsel),
    .tx_line_ref_valid(lref), .tx_framer_ref_valid(fref)
  );
  pcsm_far_end_model pcsm_far_end_model_inst (.run(run), .rx_line_clock_input(rxc), .tx_clock_input(txc));

  function automatic logic [15:0] step(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  // Expected source: k 0 rx framer, 1 tx framer, 2 tx line
  function automatic logic [2:0] esrc(input int k, input logic lt, input logic by, input logic [2:0] lb);
    logic [2:0] t;
    t = by ? PCSM_SRC_TX : PCSM_SRC_AD;
    if (lt) return PCSM_SRC_RX;
    if (k == 0) return (lb[2] || lb == PCSM_LB_ANALOG) ? t : PCSM_SRC_RX;
    if (k == 1) return (lb == PCSM_LB_PAYLOAD) ? PCSM_SRC_RX : t;
    return (lb == 3'h2 || lb == 3'h3 || lb == 3'h6) ? PCSM_SRC_RX : t;
  endfunction
  // Expected valid-reference mask for line (fr 0) or framer (fr 1) pins
  function automatic logic [4:0] emask(input logic fr, input logic lt, input logic by, input logic sel,
                                       input logic [2:0] lb);
    if (lt) return sel ? 5'h08 : 5'h07;
    if (sel && fr) return (lb == 3'h3) ? 5'h08 : (by ? 5'h10 : 5'h00);
    if (sel) return (lb == 3'h2 || lb == 3'h3 || lb == 3'h6) ? 5'h08 : (by ? 5'h10 : 5'h00);
    if (fr) begin
      case (lb)
        3'h1, 3'h3, 3'h4: return 5'h07;
        3'h6: return 5'h06;
        3'h0: return 5'h03;
        default: return 5'h02;
      endcase
    end
    case (lb)
      3'h4: return 5'h07;
      3'h2, 3'h3: return 5'h05;
      3'h6: return 5'h01;
      default: return 5'h03;
    endcase
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Bounded wait for hready at a rising edge
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      n_mismatch++;
      conclude();
    end
  endtask
  // Single transfer: address phase held to hready, then data phase
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd, input logic [2:0] sz,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    hsize <= sz;
    htrans <= 2'h2;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
    chk("hresp", hresp, 1'b0);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, PCSM_WORD_SIZE, x);
  endtask
  task automatic rdc(input string nm, input logic [31:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0000_0000, PCSM_WORD_SIZE, x);
    chk(nm, x, e);
  endtask

  initial begin
    logic [31:0] st;
    logic [31:0] c4;
    logic [2:0] s [3];
    logic [2:0] o;
    logic [2:0] lbm;
    logic lt, by, tl, tf, pl, pf;
    int sb [3];
    sb = '{PCSM_B_RXSEL, PCSM_B_TXSEL, PCSM_B_LNSEL};
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Reset values, refused accesses, default sources
    rdc("ctrl3", A3, 32'h0000_0000);
    rdc("ctrl4", A4, 32'h0000_0000);
    rdc("adapt", AA, 32'h0000_0002);
    rdc("unmapped", 32'h0000_0010, 32'h0000_0000);
    rdc("high addr", 32'h0000_0100, 32'h0000_0000);
    bus(1'b1, A4, 32'h0000_0006, 3'h0, st);
    rdc("ctrl4 byte", A4, 32'h0000_0000);
    bus(1'b0, AS, 32'h0000_0000, PCSM_WORD_SIZE, st);
    chk("rst rx src", st[PCSM_B_RXSEL +: 3], PCSM_SRC_RX);
    chk("rst tx src", st[PCSM_B_TXSEL +: 3], PCSM_SRC_AD);
    wr(AA, {29'h0000_0000, lf[2:0]});
    rdc("adapt rb", AA, {29'h0000_0000, lf[2:0]});
    $display("test reset done");
    // Every loop timing, bypass and loopback code, random timing selects
    for (int c = 0; c < 32; c++) begin
      lt = c[4];
      by = c[3];
      lbm = c[2:0];
      lf = step(lf);
      tl = lf[0];
      tf = lf[1];
      c4 = {26'h000_0000, lf[3:2], 1'b0, lbm};
      run <= 1'b0;
      repeat (4) @(posedge hclk);
      wr(A3, {28'h000_0000, tf, tl, by, lt});
      wr(A4, c4);
      rdc("ctrl4 rb", A4, c4);
      repeat (8) @(posedge hclk);
      bus(1'b0, AS, 32'h0000_0000, PCSM_WORD_SIZE, st);
      o = {lnc, txfr, rxfr};
      for (int k = 0; k < 3; k++) begin
        s[k] = esrc(k, lt, by, lbm);
        chk("source", st[sb[k] +: 3], s[k]);
        if (s[k] != PCSM_SRC_AD) chk("held level", o[k], s[k] == PCSM_SRC_RX);
      end
      chk("line mask", st[PCSM_B_LNMASK +: 5], emask(1'b0, lt, by, tl, lbm));
      chk("framer mask", st[PCSM_B_FRMASK +: 5], emask(1'b1, lt, by, tf, lbm));
      chk("line ref", lref, emask(1'b0, lt, by, tl, lbm));
      chk("framer ref", fref, emask(1'b1, lt, by, tf, lbm));
      chk("line tsel", ltsel, tl);
      chk("framer tsel", ftsel, tf);
      // Clocks running: shared sources agree, strobes mark rising edges
      run <= 1'b1;
      #1;
      pl = lnc;
      pf = txfr;
      repeat (48) begin
        @(posedge hclk);
        #1;
        o = {lnc, txfr, rxfr};
        for (int i = 0; i < 2; i++) begin
          for (int j = i + 1; j < 3; j++) begin
            if (s[i] == s[j]) chk("shared source", o[i], o[j]);
          end
        end
        chk("line strobe", lden, lnc & ~pl);
        chk("framer strobe", fden, txfr & ~pf);
        pl = lnc;
        pf = txfr;
      end
      @(posedge hclk);
      $display("test config %0d done", c);
    end
    conclude();
  end
endmodule
`default_nettype wire
